// ==== include/config_word_map.svh ====
// register offsets, field positions and reset values of the configuration decoder
`ifndef CONFIG_WORD_MAP_SVH
`define CONFIG_WORD_MAP_SVH

`define CFG_BASE_ADDR       22'h300000
`define CFG_LAST_ADDR       22'h30000B
`define OFF_OSC_SETUP_LOW   22'h300000
`define OFF_CLK_OPT_HIGH    22'h300001
`define OFF_RST_OPT_LOW     22'h300002
`define OFF_CORE_OPT_HIGH   22'h300003
`define OFF_LOCK_CTRL       22'h300010
`define OFF_SOFT_CTRL       22'h300011
`define OFF_OSC_CTRL        22'h300012
`define OFF_STATUS          22'h300013

`define UNIMPL_MASK0        8'h88
`define UNIMPL_MASK1        8'hD4
`define UNIMPL_MASK2        8'h00
`define UNIMPL_MASK3        8'h40

`define POS_POWERUP_OSC_SELECT          4
`define POS_FEXT            0
`define POS_MONITOR         5
`define POS_SWITCH          3
`define POS_PRI_ONEWAY      1
`define POS_CLKOUT          0
`define POS_BOR_MODE        6
`define POS_LPBOR           5
`define POS_IVT_ONEWAY      4
`define POS_MVEC            3
`define POS_PWRT            1
`define POS_RSTPIN          0
`define POS_XINSTR          7
`define POS_DEBUG           5
`define POS_STACK           4
`define POS_PPS_ONEWAY      3
`define POS_ZCD             2
`define POS_BROWNOUT_THRESHOLD_SELECT            0

`define PWRT_LONG_CYCLES    12'd2048
`define PWRT_MID_CYCLES     12'd512
`define PWRT_SHORT_CYCLES   12'd32
`define DIV_BY_FOUR         4'h4
`define DIV_BY_ONE          4'h1
`define OSC_FORCED_CODE     3'h6

`endif

// ==== include/config_word_pkg.sv ====
// types shared by the configuration decoder and its bench
package config_word_pkg;

  typedef enum logic [2:0] {
    OSC_EXT      = 3'h7,
    OSC_FAST_4M  = 3'h6,
    OSC_SLOW     = 3'h5,
    OSC_SECOND   = 3'h4,
    OSC_RSV3     = 3'h3,
    OSC_EXT_PLL  = 3'h2,
    OSC_RSV1     = 3'h1,
    OSC_FAST_64M = 3'h0
  } osc_source_type;

  typedef enum logic [1:0] {
    BOR_ALWAYS = 2'h3,
    BOR_AWAKE  = 2'h2,
    BOR_SOFT   = 2'h1,
    BOR_OFF    = 2'h0
  } bor_mode_type;

  typedef struct packed {
    logic [21:0] addr;
    logic [7:0]  wdata;
    logic        wr;
    logic        rd;
  } bus_req_type;

  typedef struct packed {
    logic [2:0] current_osc_select;
    logic [2:0] new_osc_select;
    logic [3:0] new_clock_divider;
    logic       fast_internal_freq_high;
    logic [2:0] ext_osc_mode;
    logic       monitor_run;
    logic       switch_allow;
    logic       clkout_drive;
  } clock_ctrl_type;

  typedef struct packed {
    logic       bor_active;
    logic [1:0] bor_threshold;
    logic       lpbor_active;
    logic       pwrt_enable;
    logic [11:0] pwrt_cycles;
    logic       reset_pin_is_reset;
    logic       stack_reset_req;
  } reset_ctrl_type;

  typedef struct packed {
    logic ext_instr_active;
    logic debugger_active;
    logic multi_vector_active;
    logic zero_cross_active;
    logic priority_lock_flag;
    logic vector_table_lock_flag;
    logic pin_select_lock_flag;
  } core_ctrl_type;

endpackage

// ==== design/config_word_decode.sv ====
// configuration byte capture and static control decode
//
// Chosen here: the address-and-strobe port.
`timescale 1ns/1ps
`default_nettype none
`include "config_word_map.svh"

// Summary of operation
// [RULE1] configuration bytes live at consecutive addresses from 300000h upward
// [RULE2] unimplemented configuration bits always read back as one
// [RULE3] power-up oscillator field picks the starting oscillator source
// [RULE4] field 000 forces current and new oscillator select to 110
// [RULE5] external mode field picks clock input, crystal or disabled
// [RULE6] clock monitor bit set runs the fail-safe monitor timer
// [RULE7] switch bit clear blocks software writes of new oscillator and divider
// [RULE8] priority one-way bit allows only one clear-then-set of its lock
// [RULE9] clock input or disabled mode with clock-out bit zero drives clock out
// [RULE10] brown-out mode: always, awake only, software controlled, or off
// [RULE11] low-power brown-out bit is active low
// [RULE12] vector-table one-way bit allows only one clear-then-set of its lock
// [RULE13] multi-vector bit set dispatches interrupts through the vector table
// [RULE14] power-up timer field picks off, 2048, 512 or 32 slow cycles
// [RULE15] low-voltage programming forces reset pin, else reset-pin bit decides
// [RULE16] extended instruction bit is active low
// [RULE17] debugger bit is active low
// [RULE18] stack fault reset bit set turns stack faults into a reset request
// [RULE19] pin-select one-way bit allows only one clear-then-set of its lock
// [RULE20] zero-cross bit zero forces detector on, one leaves it to software
// [RULE21] brown-out threshold code passes to the detector while it is enabled
// [RULE22] bytes are captured during reset and held until the next reset
module config_word_decode (
  input  wire logic                          mclk,
  input  wire logic                          srst,
  input  wire logic [3:0][7:0]               nv_bytes,
  input  wire logic                          low_voltage_program,
  input  wire logic                          sleep_active,
  input  wire logic                          stack_fault,
  input  wire config_word_pkg::bus_req_type  bus_req,
  output logic      [7:0]                    bus_rdata,
  output config_word_pkg::clock_ctrl_type    clock_ctrl,
  output config_word_pkg::reset_ctrl_type    reset_ctrl,
  output config_word_pkg::core_ctrl_type     core_ctrl
);
  import config_word_pkg::*;

  typedef struct packed {
    logic [3:0][7:0] cfg;
    clock_ctrl_type  clk;
    reset_ctrl_type  rst;
    core_ctrl_type   core;
    logic [2:0]      lock_done;
    logic            soft_brownout_enable;
    logic            zero_cross_soft_enable;
    logic [7:0]      rdata;
  } state_type;

  state_type st_ff;
  state_type nxt_st;

  // one step of a lock flag; done latches after the first 0 to 1 change
  function automatic logic [1:0] lock_step(
    input logic flag,
    input logic done,
    input logic one_way,
    input logic wr_en,
    input logic wval
  );
    logic [1:0] res;
    res = {done, flag};
    if (wr_en && !(one_way && done)) begin
      res[0] = wval;
      if (!flag && wval) begin
        res[1] = 1'b1;
      end
    end
    return res;
  endfunction

  function automatic logic [7:0] force_unimpl(
    input logic [7:0] raw,
    input logic [7:0] mask
  );
    return raw | mask;
  endfunction

  function automatic logic [2:0] start_osc(
    input logic [2:0] code
  );
    return (code == OSC_FAST_64M) ? `OSC_FORCED_CODE : code;
  endfunction

  logic [7:0] b0;
  logic [7:0] b1;
  logic [7:0] b2;
  logic [7:0] b3;
  logic [2:0] rst_osc;
  logic [2:0] fext;
  logic [1:0] bor_mode;
  logic [1:0] pwrt_sel;
  logic       fext_is_clk_in;
  logic       lk_wr;
  logic       sw_wr;
  logic       osc_wr;
  logic [1:0] lk0;
  logic [1:0] lk1;
  logic [1:0] lk2;

  always_comb begin
    nxt_st         = st_ff;
    b0             = st_ff.cfg[0];
    b1             = st_ff.cfg[1];
    b2             = st_ff.cfg[2];
    b3             = st_ff.cfg[3];
    rst_osc        = b0[`POS_POWERUP_OSC_SELECT +: 3];
    fext           = b0[`POS_FEXT +: 3];
    bor_mode       = b2[`POS_BOR_MODE +: 2];
    pwrt_sel       = b2[`POS_PWRT +: 2];
    fext_is_clk_in = fext[2];
    lk_wr          = bus_req.wr && (bus_req.addr == `OFF_LOCK_CTRL);
    sw_wr          = bus_req.wr && (bus_req.addr == `OFF_SOFT_CTRL);
    osc_wr         = bus_req.wr && (bus_req.addr == `OFF_OSC_CTRL);
    lk0            = 2'h0;
    lk1            = 2'h0;
    lk2            = 2'h0;

    if (srst) begin
      // capture is clocked under the synchronous reset, held afterwards
      nxt_st.cfg[0] = force_unimpl(nv_bytes[0], `UNIMPL_MASK0); // [RULE22] [RULE2]
      nxt_st.cfg[1] = force_unimpl(nv_bytes[1], `UNIMPL_MASK1); // [RULE2]
      nxt_st.cfg[2] = force_unimpl(nv_bytes[2], `UNIMPL_MASK2); // [RULE2]
      nxt_st.cfg[3] = force_unimpl(nv_bytes[3], `UNIMPL_MASK3); // [RULE2]
      rst_osc = nv_bytes[0][`POS_POWERUP_OSC_SELECT +: 3];
      nxt_st.clk.current_osc_select = start_osc(rst_osc); // [RULE3] [RULE4]
      nxt_st.clk.new_osc_select     = start_osc(rst_osc); // [RULE4]
      nxt_st.clk.fast_internal_freq_high = (rst_osc == OSC_FAST_64M); // [RULE3]
      nxt_st.clk.new_clock_divider  = (rst_osc == OSC_FAST_4M) ? `DIV_BY_FOUR
                                                               : `DIV_BY_ONE; // [RULE3]
      nxt_st.core.priority_lock_flag     = 1'b0;
      nxt_st.core.vector_table_lock_flag = 1'b0;
      nxt_st.core.pin_select_lock_flag   = 1'b0;
      nxt_st.lock_done              = 3'h0;
      nxt_st.soft_brownout_enable   = 1'b1;
      nxt_st.zero_cross_soft_enable = 1'b0;
      nxt_st.rdata                  = 8'h00;
      nxt_st.rst.stack_reset_req    = 1'b0;
    end else begin
      // a blocked write is dropped silently, no error is flagged
      if (osc_wr && b1[`POS_SWITCH]) begin // [RULE7]
        nxt_st.clk.new_osc_select    = bus_req.wdata[6:4];
        nxt_st.clk.new_clock_divider = bus_req.wdata[3:0];
      end
      // switch is taken one cycle after the new select; no ready handshake with the oscillators
      nxt_st.clk.current_osc_select = st_ff.clk.new_osc_select;

      lk0 = lock_step(st_ff.core.priority_lock_flag, st_ff.lock_done[0],
                      b1[`POS_PRI_ONEWAY], lk_wr, bus_req.wdata[0]); // [RULE8]
      lk1 = lock_step(st_ff.core.vector_table_lock_flag, st_ff.lock_done[1],
                      b2[`POS_IVT_ONEWAY], lk_wr, bus_req.wdata[1]); // [RULE12]
      lk2 = lock_step(st_ff.core.pin_select_lock_flag, st_ff.lock_done[2],
                      b3[`POS_PPS_ONEWAY], lk_wr, bus_req.wdata[2]); // [RULE19]
      nxt_st.core.priority_lock_flag     = lk0[0];
      nxt_st.core.vector_table_lock_flag = lk1[0];
      nxt_st.core.pin_select_lock_flag   = lk2[0];
      nxt_st.lock_done = {lk2[1], lk1[1], lk0[1]};

      if (sw_wr) begin
        nxt_st.soft_brownout_enable   = bus_req.wdata[0];
        nxt_st.zero_cross_soft_enable = bus_req.wdata[1];
      end

      nxt_st.rst.stack_reset_req = stack_fault && b3[`POS_STACK]; // [RULE18]

      nxt_st.rdata = 8'h00;
      if (bus_req.rd) begin
        case (bus_req.addr)
          `OFF_OSC_SETUP_LOW: begin
            nxt_st.rdata = b0; // [RULE1]
          end
          `OFF_CLK_OPT_HIGH: begin
            nxt_st.rdata = b1; // [RULE1]
          end
          `OFF_RST_OPT_LOW: begin
            nxt_st.rdata = b2; // [RULE1]
          end
          `OFF_CORE_OPT_HIGH: begin
            nxt_st.rdata = b3; // [RULE1]
          end
          `OFF_LOCK_CTRL: begin
            nxt_st.rdata = {2'h0, st_ff.lock_done,
                            st_ff.core.pin_select_lock_flag,
                            st_ff.core.vector_table_lock_flag,
                            st_ff.core.priority_lock_flag};
          end
          `OFF_SOFT_CTRL: begin
            nxt_st.rdata = {6'h00, st_ff.zero_cross_soft_enable,
                            st_ff.soft_brownout_enable};
          end
          `OFF_OSC_CTRL: begin
            nxt_st.rdata = {1'b0, st_ff.clk.new_osc_select,
                            st_ff.clk.new_clock_divider};
          end
          `OFF_STATUS: begin
            nxt_st.rdata = {1'b0, st_ff.clk.current_osc_select,
                            st_ff.rst.bor_active, st_ff.clk.clkout_drive,
                            st_ff.core.zero_cross_active,
                            st_ff.rst.reset_pin_is_reset};
          end
          default: begin
            // words 4 to 11 of the range are not held here and read as one
            if (bus_req.addr > `OFF_CORE_OPT_HIGH && bus_req.addr <= `CFG_LAST_ADDR) begin
              nxt_st.rdata = 8'hFF;
            end else begin
              nxt_st.rdata = 8'h00;
            end
          end
        endcase
      end
    end

    // static decode, refreshed every cycle from the held bytes
    nxt_st.clk.ext_osc_mode = fext; // [RULE5]
    nxt_st.clk.monitor_run  = b1[`POS_MONITOR]; // [RULE6]
    nxt_st.clk.switch_allow = b1[`POS_SWITCH]; // [RULE7]
    nxt_st.clk.clkout_drive = fext_is_clk_in && !b1[`POS_CLKOUT]; // [RULE9]

    case (bor_mode) // [RULE10]
      BOR_ALWAYS: begin
        nxt_st.rst.bor_active = 1'b1;
      end
      BOR_AWAKE: begin
        nxt_st.rst.bor_active = !sleep_active;
      end
      BOR_SOFT: begin
        nxt_st.rst.bor_active = st_ff.soft_brownout_enable;
      end
      default: begin
        nxt_st.rst.bor_active = 1'b0;
      end
    endcase
    // threshold held at zero while off so the detector sees a quiet code
    nxt_st.rst.bor_threshold = nxt_st.rst.bor_active ? b3[`POS_BROWNOUT_THRESHOLD_SELECT +: 2] : 2'h0; // [RULE21]
    nxt_st.rst.lpbor_active  = !b2[`POS_LPBOR]; // [RULE11]

    case (pwrt_sel) // [RULE14]
      2'h3: begin
        nxt_st.rst.pwrt_enable = 1'b0;
        nxt_st.rst.pwrt_cycles = 12'h000;
      end
      2'h2: begin
        nxt_st.rst.pwrt_enable = 1'b1;
        nxt_st.rst.pwrt_cycles = `PWRT_LONG_CYCLES;
      end
      2'h1: begin
        nxt_st.rst.pwrt_enable = 1'b1;
        nxt_st.rst.pwrt_cycles = `PWRT_MID_CYCLES;
      end
      default: begin
        nxt_st.rst.pwrt_enable = 1'b1;
        nxt_st.rst.pwrt_cycles = `PWRT_SHORT_CYCLES;
      end
    endcase

    nxt_st.rst.reset_pin_is_reset = low_voltage_program || b2[`POS_RSTPIN]; // [RULE15]
    nxt_st.core.multi_vector_active = b2[`POS_MVEC]; // [RULE13]
    nxt_st.core.ext_instr_active    = !b3[`POS_XINSTR]; // [RULE16]
    nxt_st.core.debugger_active     = !b3[`POS_DEBUG]; // [RULE17]
    nxt_st.core.zero_cross_active   = !b3[`POS_ZCD] ||
                                      st_ff.zero_cross_soft_enable; // [RULE20]
  end

  always_ff @(posedge mclk) begin
    st_ff <= nxt_st;
  end

  assign bus_rdata  = st_ff.rdata;
  assign clock_ctrl = st_ff.clk;
  assign reset_ctrl = st_ff.rst;
  assign core_ctrl  = st_ff.core;

endmodule // config_word_decode
`default_nettype wire

// ==== verif/config_core_partner.sv ====
// behavioural core side that raises stack faults and sleep on request
`timescale 1ns/1ps
`default_nettype none
module config_core_partner (
  input  wire logic mclk,
  input  wire logic fault_req,
  input  wire logic nap_req,
  output var  logic stack_fault = 1'b0,
  output var  logic sleep_active = 1'b0
);
  // launched from flops, as the real core would, so no same-edge races
  always @(posedge mclk) begin
    stack_fault  <= fault_req;
    sleep_active <= nap_req;
  end
endmodule // config_core_partner
`default_nettype wire

// ==== verif/config_word_decode_assertions.sv ====
// checker tying decoded outputs to the bytes captured in reset
`timescale 1ns/1ps
`default_nettype none
`include "config_word_map.svh"
module config_word_decode_checker (
  input wire logic                         mclk,
  input wire logic                         srst,
  input wire logic [3:0][7:0]              nv_bytes,
  input wire logic                         low_voltage_program,
  input wire logic                         sleep_active,
  input wire logic                         stack_fault,
  input wire config_word_pkg::bus_req_type bus_req,
  input wire logic [7:0]                   bus_rdata,
  input wire config_word_pkg::clock_ctrl_type clock_ctrl,
  input wire config_word_pkg::reset_ctrl_type reset_ctrl,
  input wire config_word_pkg::core_ctrl_type  core_ctrl
);
  import config_word_pkg::*;
  logic [3:0][7:0] cfg_ff;
  logic [1:0]      up_ff;
  logic            ok;
  logic [2:0]      start_osc;
  logic [11:0]     pwrt_exp;
  logic [1:0]      bor_mode;
  // own copy of the capture, so later pin changes cannot fool the checks
  always_ff @(posedge mclk) begin
    if (srst) begin
      cfg_ff <= nv_bytes | {`UNIMPL_MASK3, `UNIMPL_MASK2, `UNIMPL_MASK1, `UNIMPL_MASK0};
    end
    up_ff <= srst ? 2'h0 : up_ff + {1'b0, up_ff != 2'h3};
  end
  assign ok = up_ff == 2'h3;
  assign start_osc = (cfg_ff[0][6:4] == 3'h0) ? 3'h6 : cfg_ff[0][6:4];
  assign bor_mode = cfg_ff[2][7:6];
  assign pwrt_exp = (cfg_ff[2][2:1] == 2'h2) ? 12'h800 :
                    (cfg_ff[2][2:1] == 2'h1) ? 12'h200 : 12'h020;
  default clocking @(posedge mclk); endclocking
  default disable iff (srst);
  a_osc_start: assert property (
    $fell(srst) |-> clock_ctrl.current_osc_select == start_osc
      && clock_ctrl.new_osc_select == start_osc) else $error("start osc wrong");
  a_ext_mode: assert property (
    ok |-> clock_ctrl.ext_osc_mode == cfg_ff[0][2:0]) else $error("ext mode wrong");
  a_monitor_switch: assert property (
    ok |-> clock_ctrl.monitor_run == cfg_ff[1][5] && clock_ctrl.switch_allow == cfg_ff[1][3])
    else $error("monitor or switch wrong");
  a_clkout_pin: assert property (
    ok |-> clock_ctrl.clkout_drive == (cfg_ff[0][2] && !cfg_ff[1][0])) else $error("clkout wrong");
  a_bor_mode: assert property (
    ok |-> (bor_mode != 2'h3 || reset_ctrl.bor_active) && (bor_mode != 2'h0
      || !reset_ctrl.bor_active) && (bor_mode != 2'h2
      || reset_ctrl.bor_active == !$past(sleep_active))) else $error("bor mode wrong");
  a_bor_level: assert property (
    ok && reset_ctrl.bor_active |-> reset_ctrl.bor_threshold == cfg_ff[3][1:0])
    else $error("bor level wrong");
  a_low_active: assert property (
    ok |-> reset_ctrl.lpbor_active == !cfg_ff[2][5] && core_ctrl.ext_instr_active == !cfg_ff[3][7]
      && core_ctrl.debugger_active == !cfg_ff[3][5]) else $error("low active bit wrong");
  a_pwrt_delay: assert property (
    ok |-> reset_ctrl.pwrt_enable == (cfg_ff[2][2:1] != 2'h3)
      && (cfg_ff[2][2:1] == 2'h3 || reset_ctrl.pwrt_cycles == pwrt_exp)) else $error("pwrt wrong");
  a_reset_pin: assert property (
    ok |-> reset_ctrl.reset_pin_is_reset == ($past(low_voltage_program) || cfg_ff[2][0]))
    else $error("reset pin wrong");
  a_stack_req: assert property (
    ok |-> reset_ctrl.stack_reset_req == ($past(stack_fault) && cfg_ff[3][4]))
    else $error("stack reset wrong");
  a_vec_zcd: assert property (
    ok |-> core_ctrl.multi_vector_active == cfg_ff[2][3]
      && (cfg_ff[3][2] || core_ctrl.zero_cross_active)) else $error("vector or zcd wrong");
endmodule // config_word_decode_checker
bind config_word_decode config_word_decode_checker u_config_word_decode_checker (
  .mclk, .srst, .nv_bytes, .low_voltage_program, .sleep_active, .stack_fault,
  .bus_req, .bus_rdata, .clock_ctrl, .reset_ctrl, .core_ctrl);
`default_nettype wire

// ==== verif/config_word_decode_test.sv ====
// self-checking bench for the configuration decoder
`timescale 1ns/1ps
`default_nettype none
`include "config_word_map.svh"
module config_word_decode_test;
  import config_word_pkg::*;
  logic            mclk = 1'b0;
  logic            srst = 1'b1;
  logic [3:0][7:0] nv_bytes = '0;
  logic            low_voltage_program = 1'b0;
  logic            fault_req = 1'b0;
  logic            nap_req = 1'b0;
  logic            sleep_active;
  logic            stack_fault;
  bus_req_type     bus_req = '0;
  logic [7:0]      bus_rdata;
  clock_ctrl_type  clock_ctrl;
  reset_ctrl_type  reset_ctrl;
  core_ctrl_type   core_ctrl;
  int              miscompares = 0;
  int              n_tests = 0;
  initial begin
    forever #2 mclk = ~mclk;
  end
  config_core_partner u_config_core_partner (.mclk(mclk), .fault_req(fault_req),
    .nap_req(nap_req), .stack_fault(stack_fault), .sleep_active(sleep_active));
  config_word_decode u_config_word_decode (.mclk(mclk), .srst(srst), .nv_bytes(nv_bytes),
    .low_voltage_program(low_voltage_program), .sleep_active(sleep_active),
    .stack_fault(stack_fault), .bus_req(bus_req), .bus_rdata(bus_rdata),
    .clock_ctrl(clock_ctrl), .reset_ctrl(reset_ctrl), .core_ctrl(core_ctrl));
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_tests++;
    if (got !== exp) begin
      miscompares++;
      $display("[ERR] %s expected %0h seen %0h", what, exp, got);
    end
  endtask
  task automatic boot(input logic [3:0][7:0] b);
    @(posedge mclk);
    srst     <= 1'b1;
    nv_bytes <= b;
    repeat (3) @(posedge mclk);
    srst <= 1'b0;
  endtask
  task automatic wr(input logic [21:0] a, input logic [7:0] d);
    @(posedge mclk);
    bus_req <= '{a, d, 1'b1, 1'b0};
    @(posedge mclk);
    bus_req.wr <= 1'b0;
  endtask
  task automatic rd(input logic [21:0] a, output logic [7:0] d);
    @(posedge mclk);
    bus_req <= '{a, 8'h00, 1'b0, 1'b1};
    @(posedge mclk);
    bus_req.rd <= 1'b0;
    #1 d = bus_rdata;
  endtask
  // every start code and a spread of option bits; pins change after capture
  task automatic t_boot_codes();
    logic [3:0][7:0] b;
    logic [3:0][7:0] m;
    logic [7:0]      v;
    m = {`UNIMPL_MASK3, `UNIMPL_MASK2, `UNIMPL_MASK1, `UNIMPL_MASK0};
    for (int i = 0; i < 8; i++) begin
      b = {4{8'(i * 37)}};
      b[0] = {1'b0, 3'(i), 1'b0, 3'(i)};
      b[3] = ~b[3];
      low_voltage_program <= i[0];
      boot(b);
      nv_bytes <= ~b;
      #1 chk("cur osc", (i == 0) ? 3'h6 : 3'(i), clock_ctrl.current_osc_select);
      chk("divider", (i == 6) ? 4'h4 : 4'h1, clock_ctrl.new_clock_divider);
      if (i == 0) chk("fast freq", 1'b1, clock_ctrl.fast_internal_freq_high);
      wr(`OFF_OSC_SETUP_LOW, 8'h00);
      for (int a = 0; a < 4; a++) begin
        rd(`CFG_BASE_ADDR + 22'(a), v);
        chk("cfg byte", b[a] | m[a], v);
      end
      rd(`CFG_LAST_ADDR, v);
      chk("upper cfg", 8'hFF, v);
      rd(22'h300020, v);
      chk("unmapped", 8'h00, v);
    end
  endtask
  // locks, clock switch, stack fault and sleep with one-way bits set or clear
  task automatic t_locks(input logic one);
    logic [7:0] v;
    boot({{3'h5, one, one, 3'h5}, {3'h5, one, 4'h7}, {4'h0, one, 1'b0, one, 1'b1}, 8'h60});
    wr(`OFF_LOCK_CTRL, 8'h07);
    rd(`OFF_LOCK_CTRL, v);
    chk("lock set", 3'h7, v[2:0]);
    wr(`OFF_LOCK_CTRL, 8'h00);
    rd(`OFF_LOCK_CTRL, v);
    chk("lock clear", one ? 3'h7 : 3'h0, v[2:0]);
    chk("lock flags", one ? 3'h7 : 3'h0, {core_ctrl.pin_select_lock_flag,
      core_ctrl.vector_table_lock_flag, core_ctrl.priority_lock_flag});
    wr(`OFF_OSC_CTRL, 8'h5A);
    #1 chk("new osc", one ? 7'h5A : 7'h64,
      {clock_ctrl.new_osc_select, clock_ctrl.new_clock_divider});
    @(posedge mclk);
    fault_req <= 1'b1;
    @(posedge mclk);
    fault_req <= 1'b0;
    @(posedge mclk);
    #1 chk("stack req", one, reset_ctrl.stack_reset_req);
    chk("cur osc", one ? 3'h5 : 3'h6, clock_ctrl.current_osc_select);
    @(posedge mclk);
    nap_req <= 1'b1;
    repeat (3) @(posedge mclk);
    #1 chk("bor asleep", 1'b0, reset_ctrl.bor_active);
    @(posedge mclk);
    nap_req <= 1'b0;
    repeat (3) @(posedge mclk);
    #1 chk("bor awake", 1'b1, reset_ctrl.bor_active);
  endtask
  // software brown-out mode, zero-cross soft enable and the status byte
  task automatic t_soft();
    logic [7:0] v;
    low_voltage_program <= 1'b0;
    boot({8'h06, 8'h48, 8'h00, 8'h74});
    rd(`OFF_STATUS, v);
    chk("status", 8'h7C, v);
    wr(`OFF_SOFT_CTRL, 8'h02);
    rd(`OFF_STATUS, v);
    chk("status soft", 8'h76, v);
    rd(`OFF_SOFT_CTRL, v);
    chk("soft ctrl", 8'h02, v);
    chk("bor level off", 2'h0, reset_ctrl.bor_threshold);
    chk("low active", 4'hF, {reset_ctrl.lpbor_active, core_ctrl.ext_instr_active,
      core_ctrl.debugger_active, core_ctrl.multi_vector_active});
    chk("pwrt", 13'h1020, {reset_ctrl.pwrt_enable, reset_ctrl.pwrt_cycles});
    chk("ext mode", 3'h4, clock_ctrl.ext_osc_mode);
    chk("clkout", 1'b1, clock_ctrl.clkout_drive);
    chk("reset pin", 1'b0, reset_ctrl.reset_pin_is_reset);
    wr(`OFF_SOFT_CTRL, 8'h01);
    repeat (2) @(posedge mclk);
    #1 chk("bor soft on", 3'h6, {reset_ctrl.bor_active, reset_ctrl.bor_threshold});
    chk("zcd soft off", 1'b0, core_ctrl.zero_cross_active);
  endtask
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  // whole run is well under a thousand cycles
  initial begin
    #20000;
    miscompares++;
    end_of_test();
  end
  initial begin
    t_boot_codes();
    t_locks(1'b1);
    t_locks(1'b0);
    t_soft();
    end_of_test();
  end
endmodule // config_word_decode_test
`default_nettype wire
